// ==== inc/bst_consts.svh ====
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_IR_W 28
`define BST_OP_BYPASS0 28'h0000000
`define BST_OP_BYPASS1 28'h0ffffff
`define BST_OP_SAMPLE 28'h0fffff8
`define BST_OP_EXTEST 28'h0ffffe8
`define BST_OP_CLAMP 28'h0ffffef
`define BST_OP_IDCODE 28'h0fffffe
`define BST_OP_HIGHZ 28'h0ffffcf
`define BST_IR_CAPTURE 28'h0000001
`define BST_ID_DEFAULT 32'h12345679
`define BST_BSR_LEN 8
`endif

// ==== inc/bst_pkg.sv ====
package bst_pkg;
    typedef enum logic [15:0] {
        BST_RESET = 16'h0001, BST_IDLE = 16'h0002, BST_SEL_DR = 16'h0004,
        BST_CAP_DR = 16'h0008, BST_SH_DR = 16'h0010, BST_EX1_DR = 16'h0020,
        BST_PA_DR = 16'h0040, BST_EX2_DR = 16'h0080, BST_UP_DR = 16'h0100,
        BST_SEL_IR = 16'h0200, BST_CAP_IR = 16'h0400, BST_SH_IR = 16'h0800,
        BST_EX1_IR = 16'h1000, BST_PA_IR = 16'h2000, BST_EX2_IR = 16'h4000,
        BST_UP_IR = 16'h8000
    } bst_state_t;
    typedef enum logic [2:0] {
        BST_I_BYPASS = 3'h0, BST_I_SAMPLE = 3'h1, BST_I_EXTEST = 3'h2,
        BST_I_CLAMP = 3'h3, BST_I_IDCODE = 3'h4, BST_I_HIGHZ = 3'h5
    } bst_instr_t;
endpackage

// ==== src/bst_tap.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"
// Operation
// - TMS and TDI are sampled on each rising edge of the test clock, all test logic but TDO output stage and test-select sync runs on it.
// - TDO changes on the falling edge of the test clock.
// - The port reacts only while the test-select pin is asserted.
// - Opcodes are 28 bits; bypass is all zeros or 0ffffff (low 24 bits set), sample/preload its own code.
// - Clamp, identification and high-impedance each decode from their own opcode.
// - The identification instruction puts the variant code between TDI and TDO.
// - The TAP state machine and boundary register follow the 1149.1-2001 standard.
// - The loaded instruction selects which data register sits between TDI and TDO.
module bst_tap
    import bst_pkg::*;
#(
    parameter logic [31:0] ID_CODE = `BST_ID_DEFAULT // Arbitrary variant code
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic test_sel,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`BST_BSR_LEN-1:0] bsr_pins_in,
    output logic [`BST_BSR_LEN-1:0] bsr_pins_out,
    output logic bsr_drive,
    output logic bsr_highz,
    output logic test_active
);
    ////////////////////////////////////////////////////////////////////////
    // System side: test-select seen in the clock domain
    logic sel_s1_q;
    logic sel_s2_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
        end else begin
            sel_s1_q <= test_sel;
            sel_s2_q <= sel_s1_q;
        end
    end
    assign test_active = sel_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Link side: test-select deasserted holds TAP in reset, like a TRST
    bst_state_t state_q;
    bst_state_t state_d;
    logic [`BST_IR_W-1:0] ir_sh_q;
    logic [`BST_IR_W-1:0] ir_q;
    // Separate shift stages per data register, so a short register never
    // leaks stale bits of a longer one onto the serial output
    logic [31:0] id_sh_q;
    logic byp_q;
    logic [`BST_BSR_LEN-1:0] bsr_sh_q;
    logic [`BST_BSR_LEN:0] bsr_chain;
    logic [`BST_BSR_LEN-1:0] bsr_upd_q;
    logic tdo_q;
    logic oe_q;

    // Next state under TMS
    always_comb begin
        state_d = state_q;
        case (state_q)
            BST_RESET: state_d = tms ? BST_RESET : BST_IDLE;
            BST_IDLE: state_d = tms ? BST_SEL_DR : BST_IDLE;
            BST_SEL_DR: state_d = tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: state_d = tms ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR: state_d = tms ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: state_d = tms ? BST_UP_DR : BST_PA_DR;
            BST_PA_DR: state_d = tms ? BST_EX2_DR : BST_PA_DR;
            BST_EX2_DR: state_d = tms ? BST_UP_DR : BST_SH_DR;
            BST_UP_DR: state_d = tms ? BST_SEL_DR : BST_IDLE;
            BST_SEL_IR: state_d = tms ? BST_RESET : BST_CAP_IR;
            BST_CAP_IR: state_d = tms ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR: state_d = tms ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: state_d = tms ? BST_UP_IR : BST_PA_IR;
            BST_PA_IR: state_d = tms ? BST_EX2_IR : BST_PA_IR;
            BST_EX2_IR: state_d = tms ? BST_UP_IR : BST_SH_IR;
            BST_UP_IR: state_d = tms ? BST_SEL_DR : BST_IDLE;
            default: state_d = BST_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller state decode; one named wire per state that gates a register
    wire logic in_reset;
    wire logic in_cap_dr;
    wire logic in_sh_dr;
    wire logic in_up_dr;
    wire logic in_cap_ir;
    wire logic in_sh_ir;
    wire logic in_up_ir;
    wire logic shifting;
    assign in_reset = (state_q == BST_RESET);
    assign in_cap_dr = (state_q == BST_CAP_DR);
    assign in_sh_dr = (state_q == BST_SH_DR);
    assign in_up_dr = (state_q == BST_UP_DR);
    assign in_cap_ir = (state_q == BST_CAP_IR);
    assign in_sh_ir = (state_q == BST_SH_IR);
    assign in_up_ir = (state_q == BST_UP_IR);
    assign shifting = in_sh_dr || in_sh_ir;

    ////////////////////////////////////////////////////////////////////////
    // Opcode compares against the full 28-bit field
    wire logic op_bypass0;
    wire logic op_bypass1;
    wire logic op_sample;
    wire logic op_extest;
    wire logic op_clamp;
    wire logic op_idcode;
    wire logic op_highz;
    assign op_bypass0 = (ir_q == `BST_OP_BYPASS0);
    assign op_bypass1 = (ir_q == `BST_OP_BYPASS1);
    assign op_sample = (ir_q == `BST_OP_SAMPLE);
    assign op_extest = (ir_q == `BST_OP_EXTEST);
    assign op_clamp = (ir_q == `BST_OP_CLAMP);
    assign op_idcode = (ir_q == `BST_OP_IDCODE);
    assign op_highz = (ir_q == `BST_OP_HIGHZ);

    // Priority chain; anything unlisted falls to bypass, as do both bypass codes
    bst_instr_t instr;
    assign instr = op_sample ? BST_I_SAMPLE :
                   op_extest ? BST_I_EXTEST :
                   op_clamp ? BST_I_CLAMP :
                   op_idcode ? BST_I_IDCODE :
                   op_highz ? BST_I_HIGHZ :
                   BST_I_BYPASS;

    // Which data register sits between the serial pins
    wire logic is_id;
    wire logic is_bsr;
    wire logic is_byp;
    wire logic dr_out;
    assign is_id = (instr == BST_I_IDCODE);
    assign is_bsr = (instr == BST_I_SAMPLE) || (instr == BST_I_EXTEST);
    // Clamp and highz also shift through the one-bit bypass cell
    assign is_byp = op_bypass0 || op_bypass1 || (!is_id && !is_bsr);
    assign dr_out = is_id ? id_sh_q[0] : is_bsr ? bsr_chain[0] : byp_q;

    ////////////////////////////////////////////////////////////////////////
    // Controller and instruction register; TMS and TDI sampled here
    // Deselect acts like a TRST: it wins over every state move
    always_ff @(posedge tck) begin
        if (!test_sel) begin
            state_q <= BST_RESET;
            ir_q <= `BST_OP_IDCODE;
            ir_sh_q <= '0;
        end else begin
            state_q <= state_d;
            if (in_reset) ir_q <= `BST_OP_IDCODE;
            else if (in_up_ir) ir_q <= ir_sh_q;
            if (in_cap_ir) ir_sh_q <= `BST_IR_CAPTURE;
            else if (in_sh_ir) ir_sh_q <= {tdi, ir_sh_q[`BST_IR_W-1:1]};
        end
    end

    // Bypass cell: loads zero on capture, then one bit of delay
    always_ff @(posedge tck) begin
        if (!test_sel) begin
            byp_q <= 1'b0;
        end else if (in_cap_dr) begin
            byp_q <= 1'b0;
        end else if (in_sh_dr && is_byp) begin
            byp_q <= tdi;
        end
    end

    // Identification register: variant code captured, shifted LSB first
    always_ff @(posedge tck) begin
        if (!test_sel) begin
            id_sh_q <= '0;
        end else if (in_cap_dr && is_id) begin
            id_sh_q <= ID_CODE;
        end else if (in_sh_dr && is_id) begin
            id_sh_q <= {tdi, id_sh_q[31:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boundary cells; TDI enters the top cell, the bottom cell feeds TDO
    // The update stage only moves on Update-DR, so pins do not ripple while shifting
    assign bsr_chain[`BST_BSR_LEN] = tdi;
    genvar gi;
    generate
        for (gi = 0; gi < `BST_BSR_LEN; gi++) begin : g_cell
            assign bsr_chain[gi] = bsr_sh_q[gi];
            always_ff @(posedge tck) begin
                if (!test_sel) begin
                    bsr_sh_q[gi] <= 1'b0;
                    bsr_upd_q[gi] <= 1'b0;
                end else begin
                    if (in_cap_dr && is_bsr) bsr_sh_q[gi] <= bsr_pins_in[gi];
                    else if (in_sh_dr && is_bsr) bsr_sh_q[gi] <= bsr_chain[gi+1];
                    if (in_up_dr && is_bsr) bsr_upd_q[gi] <= bsr_sh_q[gi];
                end
            end
        end
    endgenerate

    // Falling-edge output; tester samples it on the next rise
    always_ff @(negedge tck) begin
        if (!test_sel) begin
            tdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            tdo_q <= in_sh_ir ? ir_sh_q[0] : dr_out;
            oe_q <= shifting;
        end
    end
    assign tdo = tdo_q;
    assign tdo_oe = oe_q;

    // Pin control: extest and clamp drive update values, highz floats pins
    assign bsr_pins_out = bsr_upd_q;
    assign bsr_drive = test_sel && (instr == BST_I_EXTEST || instr == BST_I_CLAMP);
    assign bsr_highz = test_sel && (instr == BST_I_HIGHZ);
endmodule
`default_nettype wire

// ==== dv/bst_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module bst_chk (
    input wire logic clock, nrst, tck, tms, test_sel, tdo, tdo_oe, bsr_drive, bsr_highz, test_active
);
    // Deselect holds the TAP in reset, so the output buffer is released
    sel_oe_a: assert property (@(posedge tck) !test_sel |=> !tdo_oe)
        else $error("oe while deselected");
    oe_rise_a: assert property (@(posedge tck) disable iff (!test_sel)
        $rose(tdo_oe) |-> !$past(tms)) else $error("oe rose without shift entry");
    oe_fall_a: assert property (@(posedge tck) disable iff (!test_sel)
        $fell(tdo_oe) |-> $past(tms)) else $error("oe fell without shift exit");
    tms_reset_a: assert property (@(posedge tck) disable iff (!test_sel)
        tms [*5] |=> !tdo_oe) else $error("five tms highs left oe on");
    // Output may only move while the test clock is low
    tdo_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe)) else $error("tdo moved on rise");
    act_on_a: assert property (@(posedge clock) disable iff (!nrst)
        test_sel [*4] |=> test_active) else $error("active late");
    act_off_a: assert property (@(posedge clock) disable iff (!nrst)
        !test_sel [*4] |=> !test_active) else $error("active stuck");
    mode_excl_a: assert property (@(posedge clock) disable iff (!nrst)
        !(bsr_drive && bsr_highz)) else $error("drive and highz together");
endmodule
bind bst_tap bst_chk u_chk (.clock, .nrst, .tck, .tms, .test_sel, .tdo, .tdo_oe, .bsr_drive,
    .bsr_highz, .test_active);
`default_nettype wire

// ==== dv/bst_tester.sv ====
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
    output logic tck = 1'b0, tms = 1'b1, tdi = 1'b0,
    input wire logic tdo
);
    // One 12 ns test-clock period; clock stays low between frames
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #5 tck = 1'b1;
        o = tdo;
        #6 tck = 1'b0;
        #1;
    endtask
    // Idle to shift, n bits LSB first, back to Idle; tdi flips on each of the two exit steps
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, tdi, o);
        if (ir) step(1'b1, tdi, o);
        repeat (2) step(1'b0, tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [31:0] ID = 32'h5a3c96e1; // Arbitrary variant code
    logic clock = 0, nrst = 0, test_sel = 0;
    logic [7:0] pins = 8'h00;
    logic [31:0] seed = 32'd66036, got, din;
    logic [27:0] op;
    wire logic tck, tms, tdi, tdo, tdo_oe, drive, highz, active;
    wire logic [7:0] pins_out;
    int num_errors = 0, tests_run = 0, cyc = 0;
    always #2 clock = ~clock;
    bst_tap #(.ID_CODE(ID)) u_bst_tap (.clock(clock), .nrst(nrst), .tck(tck), .tms(tms),
        .tdi(tdi), .test_sel(test_sel), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pins_in(pins),
        .bsr_pins_out(pins_out), .bsr_drive(drive), .bsr_highz(highz), .test_active(active));
    bst_tester u_bst_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Data register seen for an opcode: id, boundary, else one-bit bypass
    function automatic logic [31:0] exp_dr(input logic [27:0] o, input logic [31:0] d);
        if (o == 28'h0fffffe) return ID;
        if (o == 28'h0fffff8 || o == 28'h0ffffe8) return {d[23:0], pins};
        return {d[30:0], 1'b0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clock) if (++cyc > 20000) begin
        num_errors++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [27:0] ops [8] = '{28'h0, 28'h0ffffff, 28'h0fffff8, 28'h0ffffe8, 28'h0ffffef,
            28'h0fffffe, 28'h0ffffcf, 28'h0abcdef};
        repeat (5) @(negedge clock);
        nrst = 1;
        u_bst_tester.scan(1'b1, 4, 32'h5, got);
        check(active, 1'b0);
        test_sel = 1;
        repeat (5) u_bst_tester.step(1'b1, 1'b0, got[0]);
        u_bst_tester.step(1'b0, 1'b0, got[0]);
        check(active, 1'b1);
        u_bst_tester.scan(1'b0, 32, rnd(), got);
        check(got, ID);
        for (int k = 0; k < 8; k++) begin
            op = ops[k];
            u_bst_tester.scan(1'b1, 28, {4'h0, op}, got);
            check(got, 32'h1);
            check({drive, highz}, {op == 28'h0ffffe8 || op == 28'h0ffffef, op == 28'h0ffffcf});
            pins = 8'(rnd());
            din = rnd();
            u_bst_tester.scan(1'b0, 32, din, got);
            check(got, exp_dr(op, din));
            if (op == 28'h0fffff8 || op == 28'h0ffffe8) check(pins_out, din[31:24]);
            check(tdo_oe, 1'b0);
            $display("opcode %h done", op);
        end
        end_sim();
    end
endmodule
`default_nettype wire
